// ### verilog/meb_cfg.svh
// Offsets, field positions, reset values and sizes of the bus port
// Assumes inclusion by bare name from the port's design files
`ifndef MEB_CFG_SVH
`define MEB_CFG_SVH
// Register indexes on the plain register port
`define MEB_REG_PORT_ASSIGN 4'h0
`define MEB_REG_STRETCH     4'h1
`define MEB_REG_UP_DATA     4'h2
`define MEB_REG_UP_DIR      4'h3
`define MEB_REG_LO_DATA     4'h4
`define MEB_REG_LO_DIR      4'h5
`define MEB_REG_REQ_ADDR    4'h6
`define MEB_REG_REQ_DATA    4'h7
`define MEB_REG_STATUS      4'h8
// Port assignment register fields
`define MEB_PA_BUS_CLK_EN   0
`define MEB_PA_DIR_EN       1
`define MEB_PA_LOW_STRB_EN  2
`define MEB_PA_NO_DATA_EN   3
// Request data register fields
`define MEB_REQ_RD_BIT      16
`define MEB_REQ_SIZE8_BIT   17
// Status fields
`define MEB_ST_DROP_BIT     4
// Sizes and reset values
`define MEB_STRETCH_W       2
`define MEB_FIFO_DEPTH      8
`define MEB_STRETCH_RST     2'h0
`endif

// ### verilog/meb_pkg.sv
// Types shared by the multiplexed bus port
// Assumes the cfg header is compiled alongside
package meb_pkg;
  // Operating modes caught from the strap at reset
  typedef enum logic [2:0] {
    MODE_NSC, MODE_SSC, MODE_SPER, MODE_WIDE, MODE_NARROW
  } meb_mode_type;
  // Bus cycle engine states
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} meb_state_type;
  // One queued external access
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic        rd;
    logic        size8;
  } meb_req_type;
endpackage

// ### verilog/meb_bus_port.sv
// Multiplexed external bus port: clock, pin sharing, byte split, FIFO
// Assumes clock is the crystal rate; pins resolved by the surroundings
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "meb_cfg.svh"

module meb_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 8
) (
  // Clocking
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  // Honest full and empty
  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // Storage and pointers
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module meb_bus_port #(
  parameter int STRETCH_W  = `MEB_STRETCH_W,
  parameter int FIFO_DEPTH = `MEB_FIFO_DEPTH
) (
  // Clock, reset, enable, stop mode
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        stop_req,
  // Mode strap pins
  input  wire logic [2:0]  mode_strap,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Bus clock pin
  input  wire logic        bus_clock_pin_in,
  output logic             bus_clock_pin_out,
  output logic             bus_clock_pin_oe,
  // Upper and lower bus ports
  input  wire logic [7:0]  upper_bus_port_in,
  output logic [7:0]       upper_bus_port_out,
  output logic [7:0]       upper_bus_port_oe,
  input  wire logic [7:0]  lower_bus_port_in,
  output logic [7:0]       lower_bus_port_out,
  output logic [7:0]       lower_bus_port_oe,
  // Direction pin with pull-up control
  input  wire logic        dir_pin_in,
  output logic             dir_pin_out,
  output logic             dir_pin_oe,
  output logic             dir_pin_pullup,
  // Low byte strobe and data bus enable
  input  wire logic        low_byte_strobe_pin_in,
  output logic             low_byte_strobe_pin_out,
  output logic             low_byte_strobe_pin_oe,
  output logic             data_bus_enable_pin_n,
  output logic             data_bus_enable_pin_oe
);
  meb_pkg::meb_mode_type  mode_reg;
  meb_pkg::meb_state_type state_reg;
  meb_pkg::meb_req_type   cur_reg;
  meb_pkg::meb_req_type   q_data;
  meb_pkg::meb_req_type   in_req;
  logic [2:0]             mode_s1, mode_s2, misc_s1, misc_s2;
  logic [7:0]             up_s1, up_s2, lo_s1, lo_s2;
  logic [3:0]             pa_reg;
  logic [STRETCH_W-1:0]   stretch_reg;
  logic [STRETCH_W:0]     st_cnt_reg;
  logic [7:0]             gup_reg, gup_dir_reg, glo_reg, glo_dir_reg;
  logic [15:0]            req_addr_reg, rd_data_reg;
  logic [2:0]             cap0_reg, cap1_reg, cap2_reg;
  logic                   bus_clk_reg, half_reg, drop_reg;
  logic                   run, expanded, narrow, q_valid, q_ready, in_ready;
  logic                   push, start, drop, cyc_end, need_second;
  logic [15:0]            eff_addr;
  logic                   size_sig;

  assign run      = ce && !stop_req;
  assign expanded = (mode_reg == meb_pkg::MODE_WIDE) || (mode_reg == meb_pkg::MODE_NARROW);
  assign narrow   = (mode_reg == meb_pkg::MODE_NARROW);
  assign eff_addr = cur_reg.addr + {15'h0000, half_reg};
  assign size_sig = !(cur_reg.size8 || narrow);
  assign cyc_end  = (state_reg == meb_pkg::ST_DATA) && (st_cnt_reg == '0);
  assign need_second = narrow && !cur_reg.size8 && !half_reg;
  assign drop  = run && q_valid && !q_data.rd && !pa_reg[`MEB_PA_DIR_EN] && expanded
                 && (state_reg == meb_pkg::ST_IDLE);
  assign start = run && bus_clk_reg && q_valid && expanded && !drop
                 && ((state_reg == meb_pkg::ST_IDLE) || (cyc_end && !need_second))
                 && (q_data.rd || pa_reg[`MEB_PA_DIR_EN]);
  assign q_ready = start || drop;
  assign push    = ce && reg_wr && (reg_addr == `MEB_REG_REQ_DATA);
  assign in_req  = '{addr: req_addr_reg, data: reg_wdata[15:0],
                     rd: reg_wdata[`MEB_REQ_RD_BIT], size8: reg_wdata[`MEB_REQ_SIZE8_BIT]};

  // Request queue, a push while full is dropped and sets the drop flag
  meb_fifo #(.WIDTH($bits(meb_pkg::meb_req_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   (in_req),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  // Two-flop synchronisers for pins
  always_ff @(posedge clock) begin
    if (ce) begin
      mode_s1 <= mode_strap;
      mode_s2 <= mode_s1;
      misc_s1 <= {bus_clock_pin_in, dir_pin_in, low_byte_strobe_pin_in};
      misc_s2 <= misc_s1;
      up_s1   <= upper_bus_port_in;
      up_s2   <= up_s1;
      lo_s1   <= lower_bus_port_in;
      lo_s2   <= lo_s1;
    end
  end

  // Mode caught while reset is held
  always_ff @(posedge clock) begin
    if (ce && rst) begin
      case (mode_s2)
        3'h1:    mode_reg <= meb_pkg::MODE_SSC;
        3'h2:    mode_reg <= meb_pkg::MODE_SPER;
        3'h3:    mode_reg <= meb_pkg::MODE_WIDE;
        3'h4:    mode_reg <= meb_pkg::MODE_NARROW;
        default: mode_reg <= meb_pkg::MODE_NSC;
      endcase
    end
  end

  // Software registers
  always_ff @(posedge clock) begin
    if (rst) begin
      // Clock pin reset value by mode
      pa_reg       <= {3'h0, (mode_s2 != 3'h0)};
      stretch_reg  <= `MEB_STRETCH_RST;
      gup_reg      <= 8'h00;
      gup_dir_reg  <= 8'h00;
      glo_reg      <= 8'h00;
      glo_dir_reg  <= 8'h00;
      req_addr_reg <= 16'h0000;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `MEB_REG_PORT_ASSIGN: pa_reg       <= reg_wdata[3:0];
        `MEB_REG_STRETCH:     stretch_reg  <= reg_wdata[STRETCH_W-1:0];
        `MEB_REG_UP_DATA:     gup_reg      <= reg_wdata[7:0];
        `MEB_REG_UP_DIR:      gup_dir_reg  <= reg_wdata[7:0];
        `MEB_REG_LO_DATA:     glo_reg      <= reg_wdata[7:0];
        `MEB_REG_LO_DIR:      glo_dir_reg  <= reg_wdata[7:0];
        `MEB_REG_REQ_ADDR:    req_addr_reg <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Dropped write flag, set beats clear
  always_ff @(posedge clock) begin
    if (rst) begin
      drop_reg <= 1'b0;
    end else if (ce) begin
      if (drop || (push && !in_ready)) begin
        drop_reg <= 1'b1;
      end else if (reg_wr && (reg_addr == `MEB_REG_STATUS) && reg_wdata[`MEB_ST_DROP_BIT]) begin
        drop_reg <= 1'b0;
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `MEB_REG_PORT_ASSIGN: reg_rdata <= {28'h0000000, pa_reg};
          `MEB_REG_STRETCH:     reg_rdata <= 32'(stretch_reg);
          `MEB_REG_UP_DATA:     reg_rdata <= {24'h000000, up_s2};
          `MEB_REG_UP_DIR:      reg_rdata <= {24'h000000, gup_dir_reg};
          `MEB_REG_LO_DATA:     reg_rdata <= {24'h000000, lo_s2};
          `MEB_REG_LO_DIR:      reg_rdata <= {24'h000000, glo_dir_reg};
          `MEB_REG_REQ_ADDR:    reg_rdata <= {16'h0000, req_addr_reg};
          `MEB_REG_REQ_DATA:    reg_rdata <= {16'h0000, rd_data_reg};
          `MEB_REG_STATUS:      reg_rdata <= {22'h000000, misc_s2, q_valid, !in_ready,
                                              drop_reg, (state_reg != meb_pkg::ST_IDLE),
                                              mode_reg};
          default:              reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Bus clock divider and cycle engine
  always_ff @(posedge clock) begin
    if (rst) begin
      bus_clk_reg <= 1'b1;
      state_reg  <= meb_pkg::ST_IDLE;
      cur_reg    <= '0;
      half_reg   <= 1'b0;
      st_cnt_reg <= '0;
    end else if (run) begin
      bus_clk_reg <= ~bus_clk_reg;
      case (state_reg)
        meb_pkg::ST_IDLE: begin
          if (start) begin
            cur_reg   <= q_data;
            half_reg  <= 1'b0;
            state_reg <= meb_pkg::ST_ADDR;
          end
        end
        meb_pkg::ST_ADDR: begin
          st_cnt_reg <= {stretch_reg, 1'b0};
          state_reg  <= meb_pkg::ST_DATA;
        end
        meb_pkg::ST_DATA: begin
          if (st_cnt_reg != '0) begin
            bus_clk_reg <= 1'b1;
            st_cnt_reg <= st_cnt_reg - 1'b1;
          end else if (need_second) begin
            half_reg  <= 1'b1;
            state_reg <= meb_pkg::ST_ADDR;
          end else if (start) begin
            cur_reg   <= q_data;
            half_reg  <= 1'b0;
            state_reg <= meb_pkg::ST_ADDR;
          end else begin
            state_reg <= meb_pkg::ST_IDLE;
          end
        end
        default: state_reg <= meb_pkg::ST_IDLE;
      endcase
    end
  end

  // Read capture, delayed to match the synchronisers
  always_ff @(posedge clock) begin
    if (rst) begin
      cap0_reg    <= 3'h0;
      cap1_reg    <= 3'h0;
      cap2_reg    <= 3'h0;
      rd_data_reg <= 16'h0000;
    end else if (ce) begin
      cap0_reg <= 3'h0;
      if (run && cyc_end && cur_reg.rd) begin
        cap0_reg <= {1'b1, narrow, cur_reg.size8 || half_reg};
      end
      cap1_reg <= cap0_reg;
      // Pin data of the last high clock leaves the second sync flop here
      cap2_reg <= cap1_reg;
      if (cap2_reg[2]) begin
        case (cap2_reg[1:0])
          2'h0:    rd_data_reg <= {up_s2, lo_s2};
          2'h1:    rd_data_reg <= {8'h00, lo_s2};
          2'h2:    rd_data_reg <= {up_s2, 8'h00};
          default: rd_data_reg <= {rd_data_reg[15:8], up_s2};
        endcase
      end
    end
  end

  // Pin drivers, all registered together with the bus clock
  always_ff @(posedge clock) begin
    if (rst) begin
      bus_clock_pin_out       <= 1'b1;
      bus_clock_pin_oe        <= 1'b0;
      upper_bus_port_out      <= 8'h00;
      upper_bus_port_oe       <= 8'h00;
      lower_bus_port_out      <= 8'h00;
      lower_bus_port_oe       <= 8'h00;
      dir_pin_out             <= 1'b1;
      dir_pin_oe              <= 1'b0;
      dir_pin_pullup          <= 1'b1;
      low_byte_strobe_pin_out <= 1'b1;
      low_byte_strobe_pin_oe  <= 1'b0;
      data_bus_enable_pin_n   <= 1'b1;
      data_bus_enable_pin_oe  <= 1'b0;
    end else if (ce) begin
      bus_clock_pin_out <= bus_clk_reg;
      // Peripheral mode takes the clock in
      bus_clock_pin_oe  <= pa_reg[`MEB_PA_BUS_CLK_EN] && (mode_reg != meb_pkg::MODE_SPER);
      dir_pin_oe     <= expanded && pa_reg[`MEB_PA_DIR_EN];
      dir_pin_pullup <= !(expanded && pa_reg[`MEB_PA_DIR_EN]);
      dir_pin_out    <= (state_reg == meb_pkg::ST_IDLE) || cur_reg.rd;
      low_byte_strobe_pin_oe  <= expanded && pa_reg[`MEB_PA_LOW_STRB_EN];
      low_byte_strobe_pin_out <= (state_reg == meb_pkg::ST_IDLE) || !(eff_addr[0] ^ size_sig);
      // Data enable in last high clock
      data_bus_enable_pin_oe <= expanded && !pa_reg[`MEB_PA_NO_DATA_EN];
      data_bus_enable_pin_n  <= !cyc_end;
      if (!expanded) begin
        upper_bus_port_out <= gup_reg;
        upper_bus_port_oe  <= gup_dir_reg;
        lower_bus_port_out <= glo_reg;
        lower_bus_port_oe  <= glo_dir_reg;
      end else if (state_reg == meb_pkg::ST_ADDR) begin
        upper_bus_port_out <= eff_addr[15:8];
        upper_bus_port_oe  <= 8'hFF;
        lower_bus_port_out <= eff_addr[7:0];
        lower_bus_port_oe  <= 8'hFF;
      end else if (state_reg == meb_pkg::ST_DATA) begin
        upper_bus_port_oe <= cur_reg.rd ? 8'h00 : 8'hFF;
        if (narrow) begin
          upper_bus_port_out <= (cur_reg.size8 || half_reg) ? cur_reg.data[7:0]
                                                            : cur_reg.data[15:8];
        end else begin
          upper_bus_port_out <= cur_reg.size8 ? cur_reg.data[7:0] : cur_reg.data[15:8];
          lower_bus_port_out <= cur_reg.data[7:0];
          lower_bus_port_oe  <= cur_reg.rd ? 8'h00 : 8'hFF;
        end
      end else begin
        upper_bus_port_oe <= 8'h00;
        lower_bus_port_oe <= 8'h00;
      end
    end
  end

  // Checks on clock, modes and cycle shape
  property p_bus_clk_half;
    @(posedge clock) disable iff (rst)
      (run && state_reg == meb_pkg::ST_IDLE) |=> (bus_clk_reg != $past(bus_clk_reg));
  endproperty
  a_bus_clk_half: assert property (p_bus_clk_half) else $error("bus clock not halved");

  property p_nsc_off;
    @(posedge clock) disable iff (rst)
      ($past(rst) && mode_reg == meb_pkg::MODE_NSC) |-> !pa_reg[`MEB_PA_BUS_CLK_EN];
  endproperty
  a_nsc_off: assert property (p_nsc_off) else $error("clock pin on at reset");

  property p_ssc_on;
    @(posedge clock) disable iff (rst)
      ($past(rst) && mode_reg == meb_pkg::MODE_SSC) |-> pa_reg[`MEB_PA_BUS_CLK_EN];
  endproperty
  a_ssc_on: assert property (p_ssc_on) else $error("clock pin off at reset");

  property p_sper_in;
    @(posedge clock) disable iff (rst)
      (ce && mode_reg == meb_pkg::MODE_SPER) |=> !bus_clock_pin_oe;
  endproperty
  a_sper_in: assert property (p_sper_in) else $error("clock pin driven");

  property p_stop_hold;
    @(posedge clock) disable iff (rst)
      (stop_req || !ce) |=> $stable(bus_clk_reg) && $stable(state_reg);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("clock ran in stop");

  property p_second_byte;
    @(posedge clock) disable iff (rst)
      (run && cyc_end && need_second) |=> state_reg == meb_pkg::ST_ADDR && half_reg
        ##1 (!run || state_reg == meb_pkg::ST_DATA);
  endproperty
  a_second_byte: assert property (p_second_byte) else $error("no low byte cycle");

  property p_no_write;
    @(posedge clock) disable iff (rst)
      (state_reg != meb_pkg::ST_IDLE && !cur_reg.rd) |-> pa_reg[`MEB_PA_DIR_EN] || half_reg
        || $past(pa_reg[`MEB_PA_DIR_EN]);
  endproperty
  a_no_write: assert property (p_no_write) else $error("write while disabled");

  property p_dbe_high;
    @(posedge clock) disable iff (rst)
      (ce && cyc_end) |=> !data_bus_enable_pin_n && bus_clock_pin_out;
  endproperty
  a_dbe_high: assert property (p_dbe_high) else $error("enable outside clock high");
endmodule

// ### bench/meb_mem_model.sv
// External memory on the far side of the multiplexed bus
// Assumes pin levels are sampled on the system clock; the bench resolves wires
`timescale 1ns/10ps

module meb_mem_model (
  // Clock and bus width
  input  wire logic       clock,
  input  wire logic       narrow,
  // Pins as seen from outside
  input  wire logic       bus_clk,
  input  wire logic [7:0] upper,
  input  wire logic [7:0] lower,
  input  wire logic       dir,
  input  wire logic       strobe_n,
  input  wire logic       data_en_n,
  // Read data driven back
  output logic            drv_en,
  output logic [7:0]      drv_upper,
  output logic [7:0]      drv_lower
);
  logic [7:0]  mem [256];
  logic [15:0] addr_q;
  logic [15:0] wdat_q;
  logic [15:0] last_addr;
  logic        rd_q;
  logic        strb_q;
  logic        prev_q;
  logic        last_strb;
  int          hi_len;
  int          data_en_cnt;
  int          n_cycles;
  int          last_hi_len;
  int          last_data_en;

  // Blank memory and counters
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    n_cycles = 0;
    prev_q = 1'b0;
    rd_q = 1'b1;
  end

  // latch address while clock low, data while high
  always @(posedge clock) begin
    if (!bus_clk) begin
      // Bus clock runs free; only periods with data enable are real cycles
      if (prev_q && data_en_cnt != 0) begin
        n_cycles <= n_cycles + 1;
        last_hi_len <= hi_len;
        last_data_en <= data_en_cnt;
        last_addr <= addr_q;
        last_strb <= strb_q;
        if (!rd_q && narrow) mem[addr_q[7:0]] <= wdat_q[15:8];
        if (!rd_q && !narrow && !addr_q[0]) mem[addr_q[7:0]] <= wdat_q[15:8];
        if (!rd_q && !narrow && !strb_q) mem[addr_q[7:0] | 8'h01] <= wdat_q[7:0];
      end
      addr_q <= {upper, lower};
      rd_q <= dir;
      strb_q <= strobe_n;
      hi_len <= 0;
      data_en_cnt <= 0;
    end else begin
      hi_len <= hi_len + 1;
      if (!data_en_n) data_en_cnt <= data_en_cnt + 1;
      wdat_q <= {upper, lower};
    end
    prev_q <= bus_clk;
  end

  // Read data only while bus clock is high
  assign drv_en    = bus_clk && rd_q;
  assign drv_upper = narrow ? mem[addr_q[7:0]] : mem[addr_q[7:0] & 8'hFE];
  assign drv_lower = mem[addr_q[7:0] | 8'h01];
endmodule

// ### bench/test_meb_bus_port.sv
// Self-checking bench for the multiplexed bus port
// Assumes the cfg header and package are compiled first
`timescale 1ns/10ps
`include "meb_cfg.svh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module test_meb_bus_port;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        stop_req = 1'b0;
  logic        ce = 1'b1;
  logic [2:0]  mode_strap = 3'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, r, noise = 32'h0;
  logic [7:0]  upper_bus_port_out, upper_bus_port_oe, lower_bus_port_out, lower_bus_port_oe;
  logic [7:0]  up_w, lo_w, drv_upper, drv_lower, gpio_val = 8'h0;
  logic        bus_clock_pin_out, bus_clock_pin_oe, dir_pin_out, dir_pin_oe, dir_pin_pullup;
  logic        low_byte_strobe_pin_out, low_byte_strobe_pin_oe, drv_en, bus_clk_w, dir_w, strb_w;
  logic        data_bus_enable_pin_n, data_bus_enable_pin_oe, prev;
  logic        ext_clk = 1'b0, hold_ext = 1'b0, expanded = 1'b0, narrow = 1'b0;
  logic [15:0] a, d;
  int          failures = 0, n_compared = 0, n0;

  always #2 clock = ~clock;
  // far side supplies the bus clock; idle lines carry noise
  always @(posedge clock) begin
    ext_clk <= ~ext_clk;
    noise <= $urandom;
  end
  // Wire levels from every party's enables
  assign up_w   = (upper_bus_port_oe & upper_bus_port_out)
                | (~upper_bus_port_oe & (drv_en ? drv_upper : noise[7:0]));
  assign lo_w   = (lower_bus_port_oe & lower_bus_port_out)
                | (~lower_bus_port_oe & (drv_en ? drv_lower : hold_ext ? gpio_val : noise[15:8]));
  assign bus_clk_w = bus_clock_pin_oe ? bus_clock_pin_out : ext_clk;
  assign dir_w  = dir_pin_oe ? dir_pin_out : (dir_pin_pullup | noise[16]);
  assign strb_w = low_byte_strobe_pin_oe ? low_byte_strobe_pin_out : noise[17];

  meb_bus_port dut (.clock(clock), .rst(rst), .ce(ce), .stop_req(stop_req),
    .mode_strap(mode_strap), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_clock_pin_in(bus_clk_w),
    .bus_clock_pin_out(bus_clock_pin_out), .bus_clock_pin_oe(bus_clock_pin_oe),
    .upper_bus_port_in(up_w), .upper_bus_port_out(upper_bus_port_out),
    .upper_bus_port_oe(upper_bus_port_oe), .lower_bus_port_in(lo_w),
    .lower_bus_port_out(lower_bus_port_out), .lower_bus_port_oe(lower_bus_port_oe),
    .dir_pin_in(dir_w), .dir_pin_out(dir_pin_out), .dir_pin_oe(dir_pin_oe),
    .dir_pin_pullup(dir_pin_pullup), .low_byte_strobe_pin_in(strb_w),
    .low_byte_strobe_pin_out(low_byte_strobe_pin_out),
    .low_byte_strobe_pin_oe(low_byte_strobe_pin_oe),
    .data_bus_enable_pin_n(data_bus_enable_pin_n),
    .data_bus_enable_pin_oe(data_bus_enable_pin_oe));

  meb_mem_model model (.clock(clock), .narrow(narrow), .bus_clk(bus_clk_w & expanded),
    .upper(up_w), .lower(lo_w), .dir(dir_w), .strobe_n(strb_w),
    .data_en_n(data_bus_enable_pin_n),
    .drv_en(drv_en), .drv_upper(drv_upper), .drv_lower(drv_lower));

  // Register port cycles
  task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
    @(posedge clock);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad);
    @(posedge clock);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask
  task automatic push(input logic [15:0] ad, input logic [17:0] dt);
    wr(`MEB_REG_REQ_ADDR, {16'h0, ad});
    wr(`MEB_REG_REQ_DATA, {14'h0, dt});
  endtask
  task automatic do_reset(input logic [2:0] m);
    @(posedge clock);
    rst <= 1'b1;
    mode_strap <= m;
    expanded <= (m > 3'h2);
    narrow <= (m == 3'h4);
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic wait_n(input int t);
    for (int i = 0; i < 300 && model.n_cycles < t; i++) @(posedge clock);
    `CHK("bus cycles", 1'b1, logic'(model.n_cycles >= t))
    @(posedge clock);
    #1;
  endtask
  task automatic finish_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #(4 * 40000);
    failures++;
    finish_test;
  end

  initial begin
    r = $urandom(32'h3FE8);
    for (int m = 0; m < 5; m++) begin
      do_reset(m[2:0]);
      `CHK("clk_oe", logic'(m == 1 || m > 2), bus_clock_pin_oe)
      `CHK("dir_pin", 2'b01, {dir_pin_oe, dir_pin_pullup})
      `CHK("port_oe", 16'h0, {upper_bus_port_oe, lower_bus_port_oe})
      for (int i = 0; i < 6; i++) begin
        prev = bus_clock_pin_out;
        @(posedge clock);
        #1 `CHK("half rate", ~prev, bus_clock_pin_out)
      end
      rd(`MEB_REG_STATUS);
      `CHK("mode", m[2:0], r[2:0])
      wr(`MEB_REG_PORT_ASSIGN, {31'h0, m == 0});
      repeat (2) @(posedge clock);
      #1 `CHK("clk_oe_sw", logic'(m == 0), bus_clock_pin_oe)
    end
    // Single-chip ports as GPIO
    do_reset(3'h0);
    gpio_val <= $urandom;
    hold_ext <= 1'b1;
    d = $urandom;
    wr(`MEB_REG_UP_DIR, 32'hFF);
    wr(`MEB_REG_UP_DATA, {24'h0, d[7:0]});
    @(posedge clock);
    #1 `CHK("gpio_out", {8'hFF, d[7:0]}, {upper_bus_port_oe, upper_bus_port_out})
    rd(`MEB_REG_LO_DATA);
    `CHK("gpio_in", gpio_val, r[7:0])
    hold_ext <= 1'b0;
    rd(4'hF);
    `CHK("unmapped", 32'h0, r)
    // Wide mode: write refused until direction pin enabled
    do_reset(3'h3);
    n0 = model.n_cycles;
    push(16'h0010, 18'h0ABCD);
    repeat (10) @(posedge clock);
    rd(`MEB_REG_STATUS);
    `CHK("no_write", {1'b1, n0}, {r[4], model.n_cycles})
    wr(`MEB_REG_STATUS, 32'h10);
    wr(`MEB_REG_PORT_ASSIGN, 32'h7);
    for (int s = 0; s < 4; s++) begin
      wr(`MEB_REG_STRETCH, s);
      a = $urandom & 16'hFFFE;
      d = $urandom;
      n0 = model.n_cycles;
      push(a, {2'b00, d});
      wait_n(n0 + 1);
      `CHK("wide_wr", d, {model.mem[a[7:0]], model.mem[a[7:0] | 8'h01]})
      `CHK("hi_len", 1 + 2 * s, model.last_hi_len)
      `CHK("data_en", 1, model.last_data_en)
      `CHK("strobe16", 1'b0, model.last_strb)
      push(a, 18'h10000);
      wait_n(n0 + 2);
      repeat (6) @(posedge clock);
      rd(`MEB_REG_REQ_DATA);
      `CHK("wide_rd", d, r[15:0])
    end
    wr(`MEB_REG_STRETCH, 32'h0);
    // Byte writes: odd address on low lane, even address on high lane only
    n0 = model.n_cycles;
    push(16'h0041, 18'h2005A);
    push(16'h0040, 18'h200A5);
    wait_n(n0 + 2);
    `CHK("byte_odd", 8'h5A, model.mem[8'h41])
    `CHK("byte_even", {8'hA5, 1'b1}, {model.mem[8'h40], model.last_strb})
    // Stop mode freezes bus; queue fills until it refuses
    stop_req <= 1'b1;
    repeat (4) @(posedge clock);
    #1 prev = bus_clock_pin_out;
    n0 = model.n_cycles;
    for (int i = 0; i < 9; i++) push(16'h0080 + 16'(2 * i), {2'b00, 16'h1100 * 16'(i)});
    #1 `CHK("stop", {prev, n0}, {bus_clock_pin_out, model.n_cycles})
    rd(`MEB_REG_STATUS);
    `CHK("full", 3'b111, r[6:4])
    stop_req <= 1'b0;
    wait_n(n0 + 8);
    rd(`MEB_REG_STATUS);
    `CHK("empty", 1'b0, r[6])
    for (int i = 0; i < 8; i++)
      `CHK("drain", 8'(8'h11 * i), model.mem[8'(8'h80 + 2 * i)])
    // Narrow mode: two byte cycles, high byte first
    do_reset(3'h4);
    wr(`MEB_REG_PORT_ASSIGN, 32'h7);
    a = $urandom & 16'hFFFE;
    d = $urandom;
    n0 = model.n_cycles;
    push(a, {2'b00, d});
    wait_n(n0 + 2);
    `CHK("narrow_wr", d, {model.mem[a[7:0]], model.mem[a[7:0] | 8'h01]})
    `CHK("low_last", a | 16'h1, model.last_addr)
    push(a, 18'h10000);
    wait_n(n0 + 4);
    repeat (6) @(posedge clock);
    rd(`MEB_REG_REQ_DATA);
    `CHK("narrow_rd", d, r[15:0])
    // Clock enable low freezes the bus clock pin
    @(posedge clock);
    ce <= 1'b0;
    #1 prev = bus_clock_pin_out;
    repeat (4) @(posedge clock);
    #1 `CHK("ce_freeze", prev, bus_clock_pin_out)
    ce <= 1'b1;
    finish_test;
  end
endmodule
